// ### core/boot_cfg_pkg.sv
// Package: register map, field layout, reset values and shared types
package boot_cfg_pkg;
   // ==========================================================
   // Register offsets (byte offsets, one 32-bit register every 4)
   localparam logic [3:0] OFS_BOOT_WORD   = 4'h0;
   localparam logic [3:0] OFS_CFG_CONTROL = 4'h4;
   localparam logic [3:0] OFS_UNLOCK      = 4'h8;
   localparam logic [3:0] OFS_STATUS      = 4'hC;
   // ==========================================================
   // Boot word field positions
   localparam int BW_PROT_LSB  = 10;
   localparam int BW_PAIR_LSB  = 3;
   localparam int BW_TEST_BIT  = 2;
   localparam int BW_DBG_LSB   = 0;
   // ==========================================================
   // Config control bit positions and masks
   localparam int CC_PIN_LOCK  = 13;
   localparam int CC_MOD_LOCK  = 12;
   localparam int CC_TEST_EN   = 3;
   localparam int CC_TDO_EN    = 0;
   localparam logic [31:0] CC_ONES_MASK = 32'h0000_0006;
   localparam logic [31:0] UNLOCK_KEY   = 32'h0000_A5C3;
   // ==========================================================
   // Reset values, write-protect codes and boundaries
   localparam logic       RST_PIN_LOCK = 1'b0;
   localparam logic       RST_MOD_LOCK = 1'b0;
   localparam logic       RST_TEST_EN  = 1'b1;
   localparam logic       RST_TDO_EN   = 1'b1;
   localparam logic [8:0] PROT_OFF     = 9'h1FF;
   localparam logic [8:0] PROT_ALL     = 9'h000;
   localparam logic [8:0] PROT_64K     = 9'h1BF;
   localparam logic [8:0] PROT_128K    = 9'h17F;
   localparam logic [8:0] PROT_256K    = 9'h0FF;
   localparam logic [8:0] PROT_STEP_LO = 9'h1EF;
   localparam logic [18:0] PAGE_STEP   = 19'h00400;
   localparam logic [18:0] BOUND_64K   = 19'h10000;
   localparam logic [18:0] BOUND_128K  = 19'h20000;
   localparam logic [18:0] BOUND_256K  = 19'h40000;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PAIR_FOUR  = 2'b00,
      PAIR_THREE = 2'b01,
      PAIR_TWO   = 2'b10,
      PAIR_ONE   = 2'b11
   } debug_pair_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic [18:0] addr;
      logic        req;
   } flash_req_t;
endpackage

// ### core/boot_config_protect_decode.sv
// Boot configuration decode and configuration control register
`timescale 1ns/1ps
module boot_config_protect_decode (
   input  wire logic                     clk_i,          // 25 MHz system clock
   input  wire logic                     rst_n_i,        // Sync reset, active low
   input  wire logic [31:0]              boot_word_i,    // Nonvolatile boot word
   input  wire logic                     code_protect_i, // Code protect active
   input  wire logic                     big_flash_i,    // Largest flash variant
   input  wire boot_cfg_pkg::reg_req_t   reg_i,          // Register bus request
   output logic [31:0]                   rdata_o,        // Read data
   input  wire boot_cfg_pkg::flash_req_t fw_i,           // Flash write attempt
   output logic                          fw_grant_o,     // Flash write allowed
   output logic                          fw_block_o,     // Flash write rejected
   input  wire logic                     pps_wr_i,       // Pin-select write try
   output logic                          pps_wr_o,       // Pin-select write pass
   input  wire logic                     pmd_wr_i,       // Module-disable try
   output logic                          pmd_wr_o,       // Module-disable pass
   output logic [3:0]                    pair_sel_o,     // One-hot debug pair
   output logic                          debugger_en_o,  // Debugger enabled
   output logic                          test_port_en_o, // Test port enabled
   output logic                          tdo_en_o        // Two-wire data-out use
);
   import boot_cfg_pkg::*;

   // ==========================================================
   // Input synchronisers for pin-level straps
   logic [31:0] bw_meta;
   logic [31:0] bw_sync;
   logic [1:0]  cp_meta;
   logic [1:0]  cp_sync;

   // Not reset, so the straps are already settled when the seed is taken
   always_ff @(posedge clk_i) begin
      bw_meta <= boot_word_i;
      bw_sync <= bw_meta;
      cp_meta <= {big_flash_i, code_protect_i};
      cp_sync <= cp_meta;
   end

   // ==========================================================
   // Control register state
   logic        pin_lock;
   logic        mod_lock;
   logic        test_en;
   logic        tdo_en;
   logic        unlock_ok;
   logic        seeded;
   logic        lock_wr;
   logic        blocked_wr;
   logic [18:0] bound;

   // Bus decode helpers
   function automatic logic hit(input reg_req_t r, input logic [3:0] a);
      return r.addr == a;
   endfunction

   assign lock_wr = reg_i.wr && hit(reg_i, OFS_CFG_CONTROL);

   // Unlock grant flag, one lock write per unlock
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         unlock_ok <= 1'b0;
      end else if (reg_i.wr && hit(reg_i, OFS_UNLOCK)) begin
         unlock_ok <= (reg_i.wdata == UNLOCK_KEY);
      end else if (lock_wr) begin
         unlock_ok <= 1'b0;
      end
   end

   // Lock bits, guarded by the unlock grant
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pin_lock <= RST_PIN_LOCK;
         mod_lock <= RST_MOD_LOCK;
      end else if (lock_wr && unlock_ok) begin
         pin_lock <= reg_i.wdata[CC_PIN_LOCK];
         mod_lock <= reg_i.wdata[CC_MOD_LOCK];
      end
   end

   // Sticky record of a refused lock change
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         blocked_wr <= 1'b0;
      end else if (lock_wr && !unlock_ok) begin
         blocked_wr <= 1'b1;
      end else if (reg_i.rd && hit(reg_i, OFS_STATUS)) begin
         blocked_wr <= 1'b0;
      end
   end

   // Test enable seeded from boot word after reset release
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         test_en <= RST_TEST_EN;
         tdo_en  <= RST_TDO_EN;
         seeded  <= 1'b0;
      end else if (!seeded) begin
         test_en <= bw_sync[BW_TEST_BIT];
         seeded  <= 1'b1;
      end else if (lock_wr) begin
         test_en <= reg_i.wdata[CC_TEST_EN];
         tdo_en  <= reg_i.wdata[CC_TDO_EN];
      end
   end

   // ==========================================================
   // Read data, one cycle after the read strobe
   function automatic logic [31:0] cfg_image(input logic p, input logic m,
                                             input logic t, input logic d);
      logic [31:0] v;
      v = CC_ONES_MASK;
      v[CC_PIN_LOCK] = p;
      v[CC_MOD_LOCK] = m;
      v[CC_TEST_EN]  = t;
      v[CC_TDO_EN]   = d;
      return v;
   endfunction

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (reg_i.rd) begin
         case (reg_i.addr)
            OFS_BOOT_WORD:   rdata_o <= bw_sync;
            OFS_CFG_CONTROL: rdata_o <= cfg_image(pin_lock, mod_lock, test_en, tdo_en);
            OFS_UNLOCK:      rdata_o <= {31'h0, unlock_ok};
            OFS_STATUS:      rdata_o <= {12'h000, bound, blocked_wr};
            default:         rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Peripheral write gating
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pps_wr_o <= 1'b0;
         pmd_wr_o <= 1'b0;
      end else begin
         pps_wr_o <= pps_wr_i && !pin_lock;
         pmd_wr_o <= pmd_wr_i && !mod_lock;
      end
   end

   // ==========================================================
   // Debug pair and debugger decode
   debug_pair_t pair;
   logic [1:0]  dbg_eff;

   assign pair    = debug_pair_t'(bw_sync[BW_PAIR_LSB +: 2]);
   assign dbg_eff = cp_sync[0] ? 2'b11 : bw_sync[BW_DBG_LSB +: 2];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pair_sel_o    <= 4'h1;
         debugger_en_o <= 1'b0;
      end else begin
         case (pair)
            PAIR_ONE:   pair_sel_o <= 4'h1;
            PAIR_TWO:   pair_sel_o <= 4'h2;
            PAIR_THREE: pair_sel_o <= 4'h4;
            PAIR_FOUR:  pair_sel_o <= 4'h8;
            default:    pair_sel_o <= 4'h1;
         endcase
         debugger_en_o <= !dbg_eff[1];
      end
   end

   // Control outputs from flops
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         test_port_en_o <= RST_TEST_EN;
         tdo_en_o       <= RST_TDO_EN;
      end else begin
         test_port_en_o <= test_en;
         tdo_en_o       <= tdo_en;
      end
   end

   // ==========================================================
   // Flash write-protect check
   flash_guard u_guard (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .prot_field_i (bw_sync[BW_PROT_LSB +: 9]),
      .big_flash_i  (cp_sync[1]),
      .fw_i         (fw_i),
      .fw_grant_o   (fw_grant_o),
      .fw_block_o   (fw_block_o),
      .bound_o      (bound)
   );
endmodule

// ### core/flash_guard.sv
// Flash write-protect boundary decode and write check
`timescale 1ns/1ps
module flash_guard (
   input  wire logic                    clk_i,       // System clock
   input  wire logic                    rst_n_i,     // Sync reset, active low
   input  wire logic [8:0]              prot_field_i, // Write-protect field
   input  wire logic                    big_flash_i, // Largest flash variant
   input  wire boot_cfg_pkg::flash_req_t fw_i,       // Flash write attempt
   output logic                         fw_grant_o,  // Write allowed
   output logic                         fw_block_o,  // Write rejected
   output logic [18:0]                  bound_o      // Protected boundary
);
   import boot_cfg_pkg::*;

   logic [8:0]  eff;
   logic [18:0] next_bound;
   logic        next_all;
   logic        all_prot;

   // Upper two bits only act on large-flash parts
   always_comb begin
      eff = prot_field_i;
      if (!big_flash_i) begin
         eff[8:7] = 2'b11;
      end
   end

   // Boundary decode
   always_comb begin
      next_all   = 1'b0;
      next_bound = 19'h00000;
      if (eff == PROT_OFF) begin
         next_bound = 19'h00000;
      end else if (eff == PROT_ALL) begin
         next_all = 1'b1;
      end else if (eff == PROT_64K) begin
         next_bound = BOUND_64K;
      end else if (eff == PROT_128K) begin
         next_bound = BOUND_128K;
      end else if (eff == PROT_256K) begin
         next_bound = BOUND_256K;
      end else if (eff >= PROT_STEP_LO) begin
         next_bound = 19'(PAGE_STEP * 19'(PROT_OFF - eff));
      end else begin
         next_all = 1'b1; // Undefined codes fail safe
      end
   end

   // Registered boundary
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bound_o  <= 19'h00000;
         all_prot <= 1'b1;
      end else begin
         bound_o  <= next_bound;
         all_prot <= next_all;
      end
   end

   // Write check, one cycle after request
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fw_grant_o <= 1'b0;
         fw_block_o <= 1'b0;
      end else begin
         fw_grant_o <= fw_i.req && !all_prot && (fw_i.addr >= bound_o);
         fw_block_o <= fw_i.req && (all_prot || (fw_i.addr < bound_o));
      end
   end
endmodule

// ### sim/boot_cfg_sva.sv
// Checker: concurrent assertions on the decode and control ports
`timescale 1ns/1ps
module boot_cfg_sva
   import boot_cfg_pkg::*;
(
   input wire logic        clk_i,          // System clock
   input wire logic        rst_n_i,        // Sync reset, active low
   input wire logic [31:0] boot_word_i,    // Boot word
   input wire logic        code_protect_i, // Code protect
   input wire logic        big_flash_i,    // Largest flash part
   input wire reg_req_t    reg_i,          // Bus request
   input wire logic [31:0] rdata_o,        // Read data
   input wire flash_req_t  fw_i,           // Flash write try
   input wire logic        fw_grant_o,     // Flash allowed
   input wire logic        fw_block_o,     // Flash rejected
   input wire logic        pps_wr_i,       // Pin-select try
   input wire logic        pps_wr_o,       // Pin-select pass
   input wire logic        pmd_wr_i,       // Module-disable try
   input wire logic        pmd_wr_o,       // Module-disable pass
   input wire logic [3:0]  pair_sel_o,     // Debug pair
   input wire logic        debugger_en_o   // Debugger on
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Condition held long enough for the synced decode to settle
   sequence held(b);
      b [*8];
   endsequence
   sequence cfg_read;
      $past(reg_i.rd) && ($past(reg_i.addr) == OFS_CFG_CONTROL);
   endsequence
   // ==========================================================
   // Assertions
   open_off_a: assert property (held(boot_word_i[18:10] == 9'h1FF) ##0 fw_i.req |=> fw_grant_o)
      else $error("open flash write not granted");
   all_prot_a: assert property (held(big_flash_i && boot_word_i[18:10] == 9'h000) ##0 fw_i.req
      |=> fw_block_o)
      else $error("flash write passed with all protect");
   fw_answer_a: assert property ((fw_grant_o ^ fw_block_o) == $past(fw_i.req))
      else $error("flash answer missing or doubled");
   pair_one_a: assert property (held(boot_word_i[4:3] == 2'h3) |-> pair_sel_o == 4'h1)
      else $error("pair one not selected");
   dbg_force_a: assert property (held(code_protect_i) |-> !debugger_en_o)
      else $error("debugger on under code protect");
   dbg_on_a: assert property (held(!code_protect_i && !boot_word_i[1]) |-> debugger_en_o)
      else $error("debugger not enabled");
   pps_cause_a: assert property (pps_wr_o |-> $past(pps_wr_i))
      else $error("pin-select pass without try");
   pmd_cause_a: assert property (pmd_wr_o |-> $past(pmd_wr_i))
      else $error("module-disable pass without try");
   fixed_bits_a: assert property (cfg_read |-> rdata_o[31:14] == 18'h0 && rdata_o[11:4] == 8'h00
      && rdata_o[2:1] == 2'h3)
      else $error("fixed control bits wrong");
endmodule
bind boot_config_protect_decode boot_cfg_sva chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .boot_word_i(boot_word_i), .code_protect_i(code_protect_i), .big_flash_i(big_flash_i),
   .reg_i(reg_i), .rdata_o(rdata_o), .fw_i(fw_i), .fw_grant_o(fw_grant_o),
   .fw_block_o(fw_block_o), .pps_wr_i(pps_wr_i), .pps_wr_o(pps_wr_o), .pmd_wr_i(pmd_wr_i),
   .pmd_wr_o(pmd_wr_o), .pair_sel_o(pair_sel_o), .debugger_en_o(debugger_en_o));

// ### sim/boot_config_protect_decode_test.sv
// Testbench: bus, flash and debug decode checks
`timescale 1ns/1ps
module boot_config_protect_decode_test;
   import boot_cfg_pkg::*;
   logic clk_i, rst_n_i, code_protect_i, big_flash_i, pps_wr_i, pmd_wr_i;
   logic [31:0] boot_word_i;
   reg_req_t    reg_i;
   flash_req_t  fw_i;
   wire logic [31:0] rdata_o;
   wire logic        fw_grant_o, fw_block_o, pps_wr_o, pmd_wr_o;
   wire logic        debugger_en_o, test_port_en_o, tdo_en_o;
   wire logic [3:0]  pair_sel_o;
   int n_mismatch = 0;
   int compares = 0;
   logic [8:0]  codes [6] = '{9'h1FE, 9'h1F7, 9'h1EF, 9'h1BF, 9'h17F, 9'h0FF};
   logic [18:0] bnds [6] = '{19'h00400, 19'h02000, 19'h04000, 19'h10000, 19'h20000, 19'h40000};
   boot_config_protect_decode dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .boot_word_i(boot_word_i),
      .code_protect_i(code_protect_i), .big_flash_i(big_flash_i), .reg_i(reg_i),
      .rdata_o(rdata_o), .fw_i(fw_i), .fw_grant_o(fw_grant_o), .fw_block_o(fw_block_o),
      .pps_wr_i(pps_wr_i), .pps_wr_o(pps_wr_o), .pmd_wr_i(pmd_wr_i), .pmd_wr_o(pmd_wr_o),
      .pair_sel_o(pair_sel_o), .debugger_en_o(debugger_en_o),
      .test_port_en_o(test_port_en_o), .tdo_en_o(tdo_en_o));
   // ==========================================================
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] bw(logic [8:0] p, logic [1:0] pr, logic t, logic [1:0] d);
      return {13'h0000, p, 5'h1F, pr, t, d};
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk_i);
      reg_i <= {1'b1, 1'b0, a, d};
      @(posedge clk_i);
      reg_i <= '0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] exp);
      @(posedge clk_i);
      reg_i <= {1'b0, 1'b1, a, 32'h0000_0000};
      @(posedge clk_i);
      reg_i <= '0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic set_boot(logic [31:0] w);
      boot_word_i <= w;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic fw_try(logic [18:0] a, logic blk);
      @(posedge clk_i);
      fw_i <= {a, 1'b1};
      @(posedge clk_i);
      fw_i <= '0;
      #1 chk({30'h0, fw_grant_o, fw_block_o}, {30'h0, !blk, blk});
   endtask
   task automatic lock_try(logic exp_pass);
      @(posedge clk_i);
      pps_wr_i <= 1'b1;
      pmd_wr_i <= 1'b1;
      @(posedge clk_i);
      pps_wr_i <= 1'b0;
      pmd_wr_i <= 1'b0;
      #1 chk({30'h0, pps_wr_o, pmd_wr_o}, {30'h0, exp_pass, exp_pass});
   endtask
   task automatic give_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // Watchdog
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_n_i = 1'b0; code_protect_i = 1'b0; big_flash_i = 1'b1;
      pps_wr_i = 1'b0; pmd_wr_i = 1'b0; reg_i = '0; fw_i = '0;
      boot_word_i = bw(9'h1FF, 2'h3, 1'b0, 2'h3);
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(OFS_CFG_CONTROL, 32'h0000_0007);
      chk({31'h0, test_port_en_o}, 32'h0);
      wr(OFS_CFG_CONTROL, 32'hFFFF_FFFF);
      rd(OFS_CFG_CONTROL, 32'h0000_000F);
      rd(OFS_STATUS, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_0000);
      lock_try(1'b1);
      wr(OFS_UNLOCK, UNLOCK_KEY);
      wr(OFS_CFG_CONTROL, 32'h0000_3000);
      rd(OFS_CFG_CONTROL, 32'h0000_3006);
      chk({30'h0, test_port_en_o, tdo_en_o}, 32'h0);
      lock_try(1'b0);
      wr(OFS_CFG_CONTROL, 32'h0000_0009);
      wr(4'h6, 32'h0000_0000);
      rd(OFS_CFG_CONTROL, 32'h0000_300F);
      wr(OFS_UNLOCK, UNLOCK_KEY);
      wr(OFS_CFG_CONTROL, 32'h0000_0009);
      rd(OFS_CFG_CONTROL, 32'h0000_000F);
      lock_try(1'b1);
      // Protect boundaries: last address blocked, boundary granted
      for (int i = 0; i < 6; i++) begin
         set_boot(bw(codes[i], 2'h3, 1'b1, 2'h3));
         fw_try(bnds[i] - 19'h00004, 1'b1);
         fw_try(bnds[i], 1'b0);
      end
      set_boot(bw(9'h1FF, 2'h3, 1'b1, 2'h3));
      fw_try(19'h00000, 1'b0);
      set_boot(bw(9'h000, 2'h3, 1'b1, 2'h3));
      fw_try(19'h7FFFC, 1'b1);
      big_flash_i <= 1'b0;
      set_boot(bw(9'h0FF, 2'h3, 1'b1, 2'h3));
      fw_try(19'h00000, 1'b0);
      // Pair select and debugger field, all four codes
      for (int i = 0; i < 4; i++) begin
         set_boot(bw(9'h1FF, i[1:0], 1'b1, i[1:0]));
         chk({28'h0, pair_sel_o}, {28'h0, 4'h1 << (3 - i)});
         chk({31'h0, debugger_en_o}, {31'h0, !i[1]});
      end
      code_protect_i <= 1'b1;
      set_boot(bw(9'h1FF, 2'h0, 1'b1, 2'h0));
      chk({31'h0, debugger_en_o}, 32'h0);
      give_verdict();
   end
endmodule
